// ---- verilog/prbs_test_pattern_generator.v ----
`timescale 1ns/10ps
`include "prbs_gen_regs.vh"

module prbs_test_pattern_generator #(
  parameter SR_W    = `SR_WIDTH,
  parameter OCT_W   = `OCTET_BITS
) (
  input  wire              clk_in,
  input  wire              rstn_in,
  input  wire              ce_in,
  input  wire [2:0]        mode_sel_in,
  input  wire              frame_align_in,
  input  wire              payload_slot_in,
  output reg               bit_out,
  output reg               bit_valid_out,
  output reg               seq_start_out,
  output reg  [OCT_W-1:0]  octet_out,
  output reg               octet_valid_out,
  output wire              running_out
);

////////////////////////////////////////////////////////////////////////////////
// Per-mode configuration

reg  [4:0]      stages;
reg  [4:0]      tap;
reg             invert;
reg             zero_supp;

always @* begin
  stages    = `STAGES_P9;
  tap       = `TAP_P9;
  invert    = 1'b0;
  zero_supp = 1'b0;
  case (mode_sel_in)
    `MODE_P9: begin
      stages = `STAGES_P9;
      tap    = `TAP_P9;
    end
    `MODE_P11: begin
      stages = `STAGES_P11;
      tap    = `TAP_P11;
    end
    `MODE_P15: begin
      stages = `STAGES_P15;
      tap    = `TAP_P15;
      invert = 1'b1;
    end
    `MODE_P20: begin
      stages = `STAGES_P20;
      tap    = `TAP_P20;
    end
    `MODE_P20_ZS: begin
      stages    = `STAGES_P20;
      tap       = `TAP_P20_ZS;
      zero_supp = 1'b1;
    end
    `MODE_P23: begin
      stages = `STAGES_P23;
      tap    = `TAP_P23;
      invert = 1'b1;
    end
    `MODE_P29: begin
      stages = `STAGES_P29;
      tap    = `TAP_P29;
      invert = 1'b1;
    end
    `MODE_P31: begin
      stages = `STAGES_P31;
      tap    = `TAP_P31;
      invert = 1'b1;
    end
    default: begin
      stages    = `STAGES_P9;
      tap       = `TAP_P9;
      invert    = 1'b0;
      zero_supp = 1'b0;
    end
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer: reset or reselection seeds the register before running

reg  [1:0]      state_reg;
reg  [1:0]      state_next;
reg  [2:0]      mode_reg;
wire            reselect;

assign reselect    = (mode_sel_in != mode_reg);
assign running_out = state_reg[1];

always @* begin
  state_next = state_reg;
  case (state_reg)
    `ST_SEED: state_next = `ST_RUN;
    `ST_RUN: begin
      if (reselect) begin
        state_next = `ST_SEED;
      end
    end
    default: state_next = `ST_SEED;
  endcase
end

always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    state_reg <= `ST_SEED;
    mode_reg  <= `MODE_P9;
  end else if (ce_in) begin
    state_reg <= state_next;
    mode_reg  <= mode_sel_in;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Shift register, stage n held at index n-1

reg  [SR_W-1:0] sr_reg;
wire [SR_W-1:0] sr_next;
wire            feedback;
wire            last_stage;
wire [`ZS_RUN-1:0] zs_window;
wire            raw_bit;
wire            emit_bit;
wire            advance;
wire            at_seed;
wire [SR_W-1:0] len_mask;

assign feedback   = sr_reg[tap - 5'h01] ^ sr_reg[stages - 5'h01];
assign last_stage = sr_reg[stages - 5'h01];

// Stage 1 takes feedback, every other stage its neighbour
assign sr_next[0] = feedback;
genvar gi;
generate
  for (gi = 1; gi < SR_W; gi = gi + 1) begin : g_shift
    assign sr_next[gi] = sr_reg[gi-1];
  end
endgenerate

// The 14 bits emitted next sit in stages 19 down to 6
assign zs_window = sr_reg[`ZS_LOW_IDX +: `ZS_RUN];
assign raw_bit   = zero_supp ? (last_stage | ~(|zs_window)) : last_stage;
assign emit_bit  = invert ? ~raw_bit : raw_bit;

// Frame alignment bits and foreign slots hold the sequence still
assign advance = ce_in & running_out & ~reselect & payload_slot_in & ~frame_align_in;

// Seed state marks the first one of the longest ones run
assign len_mask = ~({SR_W{1'b1}} << stages);
assign at_seed  = ((sr_reg & len_mask) == (`SR_SEED & len_mask));

always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    sr_reg <= `SR_SEED;
  end else if (ce_in) begin
    if (state_reg[0]) begin
      // All-ones cannot lock up; zero state never reachable
      sr_reg <= `SR_SEED;
    end else if (advance) begin
      sr_reg <= sr_next;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Serial output: one bit per step, free of any frame phase

always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    bit_out       <= 1'b0;
    bit_valid_out <= 1'b0;
    seq_start_out <= 1'b0;
  end else if (ce_in) begin
    bit_valid_out <= advance;
    seq_start_out <= advance & at_seed;
    if (advance) begin
      bit_out <= emit_bit;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Octet assembly for Nx64k slots, first bit in the MSB

reg  [2:0]       oct_cnt_reg;
reg  [OCT_W-1:0] oct_sh_reg;

always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    oct_cnt_reg     <= `OCTET_ZERO;
    oct_sh_reg      <= {OCT_W{1'b0}};
    octet_out       <= {OCT_W{1'b0}};
    octet_valid_out <= 1'b0;
  end else if (ce_in) begin
    octet_valid_out <= 1'b0;
    if (state_reg[0]) begin
      // Octets restart when the sequence is reseeded, not at its natural wrap, so slots align to it only from a reseed
      oct_cnt_reg <= `OCTET_ZERO;
    end else if (advance) begin
      oct_sh_reg  <= {oct_sh_reg[OCT_W-2:0], emit_bit};
      oct_cnt_reg <= oct_cnt_reg + 3'h1;
      if (oct_cnt_reg == `OCTET_LAST) begin
        octet_out       <= {oct_sh_reg[OCT_W-2:0], emit_bit};
        octet_valid_out <= 1'b1;
      end
    end
  end
end

endmodule // prbs_test_pattern_generator

// ---- verilog/prbs_gen_regs.vh ----
`ifndef PRBS_GEN_REGS_VH
`define PRBS_GEN_REGS_VH

// Pattern select codes
`define MODE_P9        3'h0
`define MODE_P11       3'h1
`define MODE_P15       3'h2
`define MODE_P20       3'h3
`define MODE_P20_ZS    3'h4
`define MODE_P23       3'h5
`define MODE_P29       3'h6
`define MODE_P31       3'h7

// Register width covers the longest pattern
`define SR_WIDTH       31

// Stage numbers, counted from 1 as the taps are
`define STAGES_P9      5'h09
`define STAGES_P11     5'h0B
`define STAGES_P15     5'h0F
`define STAGES_P20     5'h14
`define STAGES_P23     5'h17
`define STAGES_P29     5'h1D
`define STAGES_P31     5'h1F

`define TAP_P9         5'h05
`define TAP_P11        5'h09
`define TAP_P15        5'h0E
`define TAP_P20        5'h03
`define TAP_P20_ZS     5'h11
`define TAP_P23        5'h12
`define TAP_P29        5'h1B
`define TAP_P31        5'h1C

// All-ones seed: non-zero for every length
`define SR_SEED        31'h7FFFFFFF

// Zero suppression looks at stages 6..19
`define ZS_LOW_IDX     5
`define ZS_RUN         14

// Octet assembly for Nx64k slots
`define OCTET_BITS     8
`define OCTET_LAST     3'h7
`define OCTET_ZERO     3'h0

// One-hot sequencer states
`define ST_SEED        2'h1
`define ST_RUN         2'h2

`endif

// ---- dv/prbs_line_sink.sv ----
`timescale 1ns/10ps
module prbs_line_sink (
  input  wire       clk_in,
  input  wire       rstn_in,
  input  wire       clear_in,
  input  wire       ce_in,
  input  wire       bit_in,
  input  wire       valid_in,
  output reg  [5:0] max_run_out
);
  reg [5:0] run_reg;
  reg       ce_reg;
  // Valid stands while stalled, so count only after enabled edges
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in || clear_in) begin
      run_reg     <= 6'h00;
      max_run_out <= 6'h00;
      ce_reg      <= 1'h0;
    end else begin
      ce_reg <= ce_in;
      if (valid_in && ce_reg) begin
        run_reg <= bit_in ? 6'h00 : run_reg + 6'h01;
        if (!bit_in && run_reg >= max_run_out) max_run_out <= run_reg + 6'h01;
      end
    end
  end
endmodule // prbs_line_sink

// ---- dv/prbs_gen_checker.sv ----
`timescale 1ns/10ps
module prbs_gen_checker #(parameter OCT_W = 8) (
  input wire             clk_in,
  input wire             rstn_in,
  input wire             ce_in,
  input wire [2:0]       mode_sel_in,
  input wire             frame_align_in,
  input wire             payload_slot_in,
  input wire             bit_out,
  input wire             bit_valid_out,
  input wire             seq_start_out,
  input wire [OCT_W-1:0] octet_out,
  input wire             octet_valid_out,
  input wire             running_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire step = ce_in && running_out && payload_slot_in && !frame_align_in;
  // Complemented line modes
  wire inv = mode_sel_in == 3'h2 || mode_sel_in > 3'h4;
  a_step_gives_bit: assert property (step && $stable(mode_sel_in) |=> bit_valid_out)
    else $error("step lost");
  a_frame_pause: assert property (ce_in && frame_align_in |=> !bit_valid_out)
    else $error("bit in frame slot");
  a_slot_pause: assert property (ce_in && !payload_slot_in |=> !bit_valid_out)
    else $error("bit outside payload");
  a_idle_bit: assert property (ce_in && !running_out |=> !bit_valid_out)
    else $error("bit while idle");
  a_stall_holds: assert property (!ce_in |=> $stable({bit_out, octet_out, bit_valid_out}))
    else $error("moved while stalled");
  a_mode_reseed: assert property (ce_in && $changed(mode_sel_in) |=> !bit_valid_out ##[0:1] !running_out)
    else $error("no reseed");
  a_start_level: assert property (seq_start_out && $stable(mode_sel_in) |-> bit_out == !inv)
    else $error("bad first bit");
  a_start_is_bit: assert property (seq_start_out |-> bit_valid_out)
    else $error("start without bit");
  a_octet_last_bit: assert property (octet_valid_out |-> bit_valid_out && octet_out[0] == bit_out)
    else $error("octet order");
  c_start: cover property (seq_start_out);
  c_octet: cover property (octet_valid_out);
  c_resume: cover property (ce_in && frame_align_in ##1 step);
endmodule // prbs_gen_checker

bind prbs_test_pattern_generator prbs_gen_checker #(.OCT_W(OCT_W)) chk (.*);

// ---- dv/test_prbs_test_pattern_generator.sv ----
`timescale 1ns/10ps
module test_prbs_test_pattern_generator;
  reg         clk_in = 1'h0, rstn_in = 1'h0, ce_in = 1'h0, frame_align_in = 1'h0;
  reg         payload_slot_in = 1'h0, clr = 1'h1, eb, full;
  reg  [2:0]  mode_sel_in = 3'h0;
  reg  [30:0] st, mk;
  reg  [7:0]  oct;
  reg  [31:0] rnd = 32'h96C6D61F;
  wire        bit_out, bit_valid_out, seq_start_out, octet_valid_out, running_out;
  wire [7:0]  octet_out;
  wire [5:0]  max_run;
  integer     failures = 0, samples_checked = 0, cnt, m;
  integer     nst [0:7] = '{9, 11, 15, 20, 20, 23, 29, 31};
  integer     ntap [0:7] = '{5, 9, 14, 3, 17, 18, 27, 28};

  always #20 clk_in = ~clk_in;

  prbs_test_pattern_generator dut (.*);
  prbs_line_sink sink (.clk_in(clk_in), .rstn_in(rstn_in), .clear_in(clr), .ce_in(ce_in), .bit_in(bit_out),
    .valid_in(bit_valid_out), .max_run_out(max_run));

  ////////////////////////////////////////
  function [31:0] xs(input [31:0] x);
    xs = x ^ (x << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task mstep;
    integer n;
    begin
      n = nst[mode_sel_in];
      mk = (31'h1 << n) - 31'h1;
      full = (st & mk) == mk;
      eb = mode_sel_in == 3'h4 ? st[19] | ~|st[18:5] : st[n-1];
      if (mode_sel_in == 3'h2 || mode_sel_in > 3'h4) eb = ~eb;
      st = {st[29:0], st[ntap[mode_sel_in]-1] ^ st[n-1]};
      oct = {oct[6:0], eb};
      cnt = cnt + 1;
    end
  endtask
  task run(input integer nb);
    integer t;
    begin
      for (t = 0; t < 20 * nb && cnt < nb; t = t + 1) begin
        @(negedge clk_in);
        if (ce_in && bit_valid_out) begin
          mstep;
          chk(bit_out, eb);
          chk(seq_start_out, full);
          chk(octet_valid_out, cnt % 8 == 0);
          if (cnt % 8 == 0) chk(octet_out, oct);
        end
        rnd = xs(rnd);
        ce_in = rnd[0] | rnd[1];
        frame_align_in = rnd[4:2] == 3'h0;
        payload_slot_in = rnd[7:5] != 3'h0;
      end
      if (cnt < nb) begin
        failures = failures + 1;
        test_done;
      end
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    rstn_in = 1'h1;
    for (m = 0; m < 8; m = m + 1) begin
      @(negedge clk_in);
      mode_sel_in = m[2:0];
      ce_in = 1'h1;
      payload_slot_in = 1'h0;
      clr = 1'h1;
      repeat (3) @(negedge clk_in);
      chk(running_out, 1);
      clr = 1'h0;
      st = 31'h7FFFFFFF;
      cnt = 0;
      run(m == 0 ? 600 : 300);
      if (m == 2 || m > 4)
        chk(max_run, nst[m]);
      else
        chk(max_run < (m == 4 ? 15 : nst[m]), 1);
    end
    // Reset mid-stream must restart from the seed
    @(negedge clk_in);
    rstn_in = 1'h0;
    @(negedge clk_in);
    rstn_in = 1'h1;
    st = 31'h7FFFFFFF;
    cnt = 0;
    run(200);
    // Reference checker stays in sync only below one error in five
    chk(failures * 5 < samples_checked, 1);
    test_done;
  end
endmodule // test_prbs_test_pattern_generator
